// >>> rtl/eoc_channel.v
// one external output channel: relay or linear value computed for the bus master
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "eoc_regs.vh"

// Notes on behaviour
// [RL1] above mode: relay high while source is above the level.
// [RL2] below mode: relay high while source is below the level.
// [RL3] inside mode: relay high between lower and upper bound, else low.
// [RL4] outside mode: relay high outside lower-to-upper range, low inside.
// [RL5] hysteresis offset moves every switching boundary.
// [RL6] hysteresis symmetric: on beyond level plus, off beyond level minus.
// [RL7] low-to-high change waits the turn-on delay.
// [RL8] high-to-low change waits the turn-off delay.
// [RL9] high state lasts at least the minimum high time.
// [RL10] low state lasts at least the minimum low time.
// [RL11] relay low sends zero, high sends 65535.
// [RL12] alarm reaction: no change, immediate low, immediate high, or timed change.
// [RL13] active relay channel in disabled mode sends zero.
// [RL14] linear input clamped from below to input lower bound.
// [RL15] linear input clamped from above to input upper bound.
// [RL16] input lower maps to output lower, input upper to output upper.
// [RL17] scaled output never below output lower value; with a falling range the code floors it at the output upper value instead.
// [RL18] scaled output never above output upper value; with a falling range the code caps it at the output lower value instead.
// [RL19] linear alarm source sends the alarm value.
// [RL20] linear undefined source or all levels zero sends zero.
// [RL21] value recomputed on every measurement update and strobed out.
module eoc_channel #(
  parameter TICK_CYC = `EOC_TICK_US * `EOC_CLK_MHZ
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [15:0] src_value,
  input  wire        src_stb,
  input  wire        src_err,
  input  wire        source_overrange_flag,
  input  wire        source_underrange_flag,
  input  wire        src_undef,
  output reg  [15:0] out_value,
  output reg         out_stb,
  output reg         relay_state
);

  // ****************************************************************
  // configuration storage
  // ****************************************************************
  reg  [15:0] cfg_r [0:`EOC_CFG_NUM-1];
  genvar      gi;

  // one flip-flop word per configuration entry
  generate
    for (gi = 0; gi < `EOC_CFG_NUM; gi = gi + 1)
    begin : g_cfg
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          cfg_r[gi] <= `EOC_RST_VAL;
        else if (reg_wr && (reg_addr == gi))
          cfg_r[gi] <= reg_wdata;
      end
    end
  endgenerate

  wire [15:0] ctrl    = cfg_r[`EOC_OFF_CTRL];
  wire        linear  = ctrl[`EOC_CTRL_LINEAR];
  wire        active  = ctrl[`EOC_CTRL_ACTIVE];
  wire [2:0]  mode    = ctrl[`EOC_CTRL_MODE_MSB:`EOC_CTRL_MODE_LSB];
  wire [2:0]  alm_sel = ctrl[`EOC_CTRL_ALM_MSB:`EOC_CTRL_ALM_LSB];

  // ****************************************************************
  // millisecond tick divider
  // ****************************************************************
  reg  [31:0] div_r;
  reg         tick_r;

  // one-cycle enable every TICK_CYC clocks
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b0;
    end
    else if (div_r == TICK_CYC - 1)
    begin
      div_r  <= 32'h00000000;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // ****************************************************************
  // measurement capture
  // ****************************************************************
  reg  [15:0] src_r;
  reg         alm_r;
  reg         undef_r;
  reg         upd1_r;
  reg         upd2_r;
  wire        alm_in = src_err | source_overrange_flag | source_underrange_flag;

  // latch each measurement and its condition flags
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_r   <= 16'h0000;
      alm_r   <= 1'b0;
      undef_r <= 1'b0;
      upd1_r  <= 1'b0;
      upd2_r  <= 1'b0;
    end
    else
    begin
      upd1_r <= src_stb;
      upd2_r <= upd1_r;
      if (src_stb)
      begin
        src_r   <= src_value;
        alm_r   <= alm_in;
        undef_r <= src_undef;
      end
    end
  end

  // ****************************************************************
  // relay comparator with hysteresis
  // ****************************************************************
  wire signed [17:0] s_v  = {2'b00, src_value};
  wire signed [17:0] h_v  = {2'b00, cfg_r[`EOC_OFF_HYST]};
  wire signed [17:0] l_v  = {2'b00, cfg_r[`EOC_OFF_LEVEL]};
  wire signed [17:0] lo_v = {2'b00, cfg_r[`EOC_OFF_LOWER]};
  wire signed [17:0] up_v = {2'b00, cfg_r[`EOC_OFF_UPPER]};
  wire               lvl_over  = s_v > l_v + h_v;             // RL6
  wire               lvl_under = s_v < l_v - h_v;             // RL6
  wire               win_in    = (s_v > lo_v + h_v) && (s_v < up_v - h_v);  // RL5
  wire               win_out   = (s_v < lo_v - h_v) || (s_v > up_v + h_v);  // RL5
  reg                set_c;
  reg                clr_c;

  // set and clear conditions for each mode
  always @*
  begin
    set_c = 1'b0;
    clr_c = 1'b0;
    case (mode)
      `EOC_MODE_ABOVE:
      begin
        set_c = lvl_over;                                     // RL1
        clr_c = lvl_under;
      end
      `EOC_MODE_BELOW:
      begin
        set_c = lvl_under;                                    // RL2
        clr_c = lvl_over;
      end
      `EOC_MODE_INSIDE:
      begin
        set_c = win_in;                                       // RL3
        clr_c = win_out;
      end
      `EOC_MODE_OUTSIDE:
      begin
        set_c = win_out;                                      // RL4
        clr_c = win_in;
      end
      default:
      begin
        set_c = 1'b0;
        clr_c = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // requested relay state
  // ****************************************************************
  reg         req_r;
  wire        relay_act = active && !linear && (mode != `EOC_MODE_DIS);

  // update the request once per measurement
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      req_r <= 1'b0;
    else if (!relay_act)
      req_r <= 1'b0;
    else if (src_stb && alm_in)
    begin
      case (alm_sel)
        `EOC_ALM_IMM_OFF: req_r <= 1'b0;                      // RL12
        `EOC_ALM_IMM_ON:  req_r <= 1'b1;                      // RL12
        `EOC_ALM_TIM_OFF: req_r <= 1'b0;                      // RL12
        `EOC_ALM_TIM_ON:  req_r <= 1'b1;                      // RL12
        default:          req_r <= req_r;                     // RL12
      endcase
    end
    else if (src_stb)
    begin
      if (set_c)
        req_r <= 1'b1;
      else if (clr_c)
        req_r <= 1'b0;
    end
  end

  // ****************************************************************
  // switch delays and minimum state times
  // ****************************************************************
  reg  [15:0] dly_cnt_r;
  reg  [15:0] min_cnt_r;
  reg         chg_r;
  wire [15:0] dly_tgt  = relay_state ? cfg_r[`EOC_OFF_OFF_DLY] : cfg_r[`EOC_OFF_ON_DLY];
  wire [15:0] min_new  = relay_state ? cfg_r[`EOC_OFF_MIN_OFF] : cfg_r[`EOC_OFF_MIN_ON];
  wire        imm_off  = alm_r && (alm_sel == `EOC_ALM_IMM_OFF);
  wire        imm_on   = alm_r && (alm_sel == `EOC_ALM_IMM_ON);
  wire        dly_done = dly_cnt_r >= dly_tgt;
  wire        min_done = min_cnt_r == 16'h0000;

  // relay state machine with delay and hold counters
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      relay_state <= 1'b0;
      dly_cnt_r   <= 16'h0000;
      min_cnt_r   <= 16'h0000;
      chg_r       <= 1'b0;
    end
    else
    begin
      chg_r <= 1'b0;
      if (tick_r && !min_done)
        min_cnt_r <= min_cnt_r - 16'h0001;                    // RL9
      if (!relay_act)
      begin
        relay_state <= 1'b0;                                  // RL13
        dly_cnt_r   <= 16'h0000;
        min_cnt_r   <= 16'h0000;
      end
      else if ((imm_off && relay_state) || (imm_on && !relay_state))
      begin
        relay_state <= imm_on;                                // RL12
        dly_cnt_r   <= 16'h0000;
        min_cnt_r   <= min_new;
        chg_r       <= 1'b1;
      end
      else if (imm_off || imm_on)
        dly_cnt_r <= 16'h0000;
      else if (req_r != relay_state)
      begin
        if (dly_done && min_done)
        begin
          relay_state <= req_r;                               // RL7
          dly_cnt_r   <= 16'h0000;
          min_cnt_r   <= min_new;                             // RL10
          chg_r       <= 1'b1;
        end
        else if (tick_r && !dly_done)
          dly_cnt_r <= dly_cnt_r + 16'h0001;                  // RL8
      end
      else
        dly_cnt_r <= 16'h0000;
    end
  end

  // ****************************************************************
  // linear path and output value
  // ****************************************************************
  wire [15:0] lin_val;
  wire        lvl_zero = (cfg_r[`EOC_OFF_IN_LO] == 16'h0000) &&
                         (cfg_r[`EOC_OFF_IN_HI] == 16'h0000) &&
                         (cfg_r[`EOC_OFF_OUT_LO] == 16'h0000) &&
                         (cfg_r[`EOC_OFF_OUT_HI] == 16'h0000) &&
                         (cfg_r[`EOC_OFF_ALARM] == 16'h0000);
  reg  [15:0] val_nxt;

  eoc_lin_scale u_scale (
    .src    (src_r),
    .in_lo  (cfg_r[`EOC_OFF_IN_LO]),
    .in_hi  (cfg_r[`EOC_OFF_IN_HI]),
    .out_lo (cfg_r[`EOC_OFF_OUT_LO]),
    .out_hi (cfg_r[`EOC_OFF_OUT_HI]),
    .result (lin_val)
  );

  // select the value the bus master sends
  always @*
  begin
    if (!linear)
      val_nxt = relay_state ? `EOC_RELAY_HIGH : `EOC_RELAY_LOW;   // RL11
    else if (undef_r || lvl_zero)
      val_nxt = 16'h0000;                                     // RL20
    else if (alm_r)
      val_nxt = cfg_r[`EOC_OFF_ALARM];                        // RL19
    else
      val_nxt = lin_val;
  end

  // present a fresh value after each update or relay change while the channel is active
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_value <= 16'h0000;
      out_stb   <= 1'b0;
    end
    else
    begin
      out_stb <= active && (upd2_r || chg_r);                 // RL21
      if (active && (upd2_r || chg_r))
        out_value <= val_nxt;
      else if (!active)
        out_value <= 16'h0000;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_addr == `EOC_OFF_STATUS)
        reg_rdata <= {13'h0000, alm_r, req_r, relay_state};
      else if (reg_addr == `EOC_OFF_VALUE)
        reg_rdata <= out_value;
      else
        reg_rdata <= cfg_r[reg_addr];
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule // eoc_channel

// >>> rtl/eoc_regs.vh
// register offsets, field positions, codes and timing constants of the external output channel
`ifndef EOC_REGS_VH
`define EOC_REGS_VH

// ****************************************************************
// register offsets (word index on the plain register port)
// ****************************************************************
`define EOC_ADDR_W        4
`define EOC_DATA_W        16
`define EOC_CFG_NUM       14
`define EOC_OFF_CTRL      4'h0
`define EOC_OFF_LEVEL     4'h1
`define EOC_OFF_LOWER     4'h2
`define EOC_OFF_UPPER     4'h3
`define EOC_OFF_HYST      4'h4
`define EOC_OFF_ON_DLY    4'h5
`define EOC_OFF_OFF_DLY   4'h6
`define EOC_OFF_MIN_ON    4'h7
`define EOC_OFF_MIN_OFF   4'h8
`define EOC_OFF_IN_LO     4'h9
`define EOC_OFF_IN_HI     4'hA
`define EOC_OFF_OUT_LO    4'hB
`define EOC_OFF_OUT_HI    4'hC
`define EOC_OFF_ALARM     4'hD
`define EOC_OFF_STATUS    4'hE
`define EOC_OFF_VALUE     4'hF

// ****************************************************************
// control register fields
// ****************************************************************
`define EOC_CTRL_LINEAR   0
`define EOC_CTRL_ACTIVE   1
`define EOC_CTRL_MODE_LSB 2
`define EOC_CTRL_MODE_MSB 4
`define EOC_CTRL_ALM_LSB  5
`define EOC_CTRL_ALM_MSB  7

// ****************************************************************
// relay modes and alarm reactions
// ****************************************************************
`define EOC_MODE_DIS      3'h0
`define EOC_MODE_ABOVE    3'h1
`define EOC_MODE_BELOW    3'h2
`define EOC_MODE_INSIDE   3'h3
`define EOC_MODE_OUTSIDE  3'h4
`define EOC_ALM_NOCHG     3'h0
`define EOC_ALM_IMM_OFF   3'h1
`define EOC_ALM_IMM_ON    3'h2
`define EOC_ALM_TIM_OFF   3'h3
`define EOC_ALM_TIM_ON    3'h4

// ****************************************************************
// reset values and output encodings
// ****************************************************************
`define EOC_RST_VAL       16'h0000
`define EOC_RELAY_LOW     16'h0000
`define EOC_RELAY_HIGH    16'hFFFF

// ****************************************************************
// timing: one timing unit is one millisecond
// ****************************************************************
`define EOC_CLK_MHZ       200
`define EOC_TICK_US       1000

`endif

// >>> rtl/eoc_lin_scale.v
// linear scaling with input and output clamping for the external output channel
`timescale 1ns/1ps

module eoc_lin_scale (
  input  wire [15:0] src,
  input  wire [15:0] in_lo,
  input  wire [15:0] in_hi,
  input  wire [15:0] out_lo,
  input  wire [15:0] out_hi,
  output reg  [15:0] result
);

  reg signed [17:0] x_c;
  reg signed [17:0] dx;
  reg signed [17:0] dy;
  reg signed [35:0] prod;
  reg signed [35:0] quot;
  reg signed [35:0] y;
  reg signed [35:0] y_min;
  reg signed [35:0] y_max;

  // clamp source to input bounds, map, clamp to output bounds
  always @*
  begin
    x_c = {2'b00, src};
    if (src < in_lo)
      x_c = {2'b00, in_lo};                                   // RL14
    if (src > in_hi)
      x_c = {2'b00, in_hi};                                   // RL15
    dx    = {2'b00, in_hi} - {2'b00, in_lo};
    dy    = {2'b00, out_hi} - {2'b00, out_lo};
    prod  = (x_c - $signed({2'b00, in_lo})) * dy;             // signed: falling output range
    quot  = (dx == 18'sh00000) ? 36'sh000000000 : prod / dx;
    y     = quot + {20'h00000, out_lo};                       // RL16
    y_min = (out_lo < out_hi) ? {20'h00000, out_lo} : {20'h00000, out_hi};
    y_max = (out_lo < out_hi) ? {20'h00000, out_hi} : {20'h00000, out_lo};
    if (y < y_min)
      y = y_min;                                              // RL17
    if (y > y_max)
      y = y_max;                                              // RL18
    result = y[15:0];
  end

endmodule // eoc_lin_scale

// >>> verif/eoc_slave_model.sv
// remote slave model holding the last register value sent by the channel
`timescale 1ns/1ps

module eoc_slave_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] hold_r
);
  // keep each value written by the master until the next write
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      hold_r <= 16'h0000;
    else if (wr_en)
      hold_r <= wr_data;
endmodule // eoc_slave_model

// >>> verif/eoc_channel_properties.sv
// port checks of the external output channel
`timescale 1ns/1ps

module eoc_channel_chk (
  input wire        clk,
  input wire        rst_b,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        src_stb,
  input wire [15:0] out_value,
  input wire        out_stb,
  input wire        relay_state
);
  reg [7:0] ctrl_r;
  reg [3:0] idle_r;

  // shadow of the control byte and history of inactive cycles
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl_r <= 8'h00;
      idle_r <= 4'hF;
    end
    else
    begin
      if (reg_wr && reg_addr == 4'h0)
        ctrl_r <= reg_wdata[7:0];
      idle_r <= {idle_r[2:0], ~ctrl_r[1]};
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_value_read: assert property (
    reg_rd && reg_addr == 4'hF ##1 !out_stb |-> reg_rdata == $past(out_value))
    else $error("value register differs from output");
  a_ctrl_read: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[7:0] == $past(ctrl_r))
    else $error("control readback wrong");
  a_status_relay: assert property (reg_rd && reg_addr == 4'hE |=> reg_rdata[0] == $past(relay_state))
    else $error("status relay bit wrong");
  a_relay_levels: assert property (
    out_stb && ctrl_r[1:0] == 2'b10 |-> out_value == 16'h0000 || out_value == 16'hFFFF)
    else $error("relay value not zero or full scale");
  a_disabled_zero: assert property (
    out_stb && ctrl_r[4:0] == 5'b00010 |-> out_value == 16'h0000)
    else $error("disabled relay sent nonzero");
  a_inactive_quiet: assert property (
    idle_r == 4'hF && !ctrl_r[1] |-> !out_stb && out_value == 16'h0000)
    else $error("inactive channel produced output");
  a_update_lat: assert property (src_stb && ctrl_r[1] |-> ##3 out_stb)
    else $error("no output three cycles after update");
  a_flip_sent: assert property (
    $changed(relay_state) && ctrl_r[1:0] == 2'b10 && ctrl_r[4:2] != 3'h0
    |-> ##[0:3] (out_stb && out_value == {16{relay_state}}))
    else $error("relay change not sent");
endmodule // eoc_channel_chk

bind eoc_channel eoc_channel_chk chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .src_stb(src_stb), .out_value(out_value), .out_stb(out_stb), .relay_state(relay_state));

// >>> verif/test_eoc_channel.sv
// self-checking bench for the external output channel
`timescale 1ns/1ps
`include "eoc_regs.vh"

module test_eoc_channel;
  localparam [207:0] cfg_init = {16'h004D, 16'h07D0, 16'h0190, 16'h01F4, 16'h0064,
    64'h0, 16'h0005, 16'h0032, 16'h000A, 16'h001E};
  reg         clk;
  reg         rst_b;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [15:0] reg_rdata;
  reg  [15:0] src_value;
  reg         src_stb;
  reg  [3:0]  flags;
  wire [15:0] out_value;
  wire        out_stb;
  wire        relay_state;
  wire [15:0] slave_val;
  reg         rd_d;
  reg  [7:0]  ctl;
  reg  [15:0] exp_q[$];
  integer     errors;
  integer     n_tests;
  integer     cyc;
  integer     seed;
  integer     i;
  integer     n;
  integer     r;

  eoc_channel #(.TICK_CYC(10)) dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_value(src_value), .src_stb(src_stb), .src_err(flags[3]),
    .source_overrange_flag(flags[2]), .source_underrange_flag(flags[1]),
    .src_undef(flags[0]), .out_value(out_value), .out_stb(out_stb),
    .relay_state(relay_state));
  eoc_slave_model slave_u (.clk(clk), .rst_b(rst_b), .wr_en(out_stb), .wr_data(out_value),
    .hold_r(slave_val));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ********
  // tasks
  // ********
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task summarize;
    begin
      if (errors == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // one register cycle; a read notes its expected answer
  task bus(input w, input [3:0] a, input [15:0] v);
    begin
      if (!w)
        exp_q.push_back(v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask

  task meas(input [15:0] v, input [3:0] f);
    begin
      @(posedge clk);
      src_value <= v;
      flags <= f;
      src_stb <= 1'b1;
      @(posedge clk);
      src_stb <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask

  // set control if changed, send a measurement, check value register and slave
  task step(input [7:0] c, input [3:0] f, input [15:0] v, input [15:0] e);
    begin
      if (c !== ctl)
        bus(1'b1, `EOC_OFF_CTRL, {8'h00, c});
      ctl = c;
      meas(v, f);
      bus(1'b0, `EOC_OFF_VALUE, e);
      chk(slave_val, e);
    end
  endtask

  task wait_relay(input v);
    begin
      n = 0;
      while (relay_state !== v && n < 300)
      begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask

  // compare read answers with the oldest note, and cut a hang short
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    cyc = cyc + 1;
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
    if (cyc == 5000)
    begin
      errors = errors + 1;
      summarize;
    end
  end

  initial
  begin
    seed = 7641;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    ctl = 8'h00;
    rd_d = 1'b0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_value = 16'h0000;
    src_stb = 1'b0;
    flags = 4'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 16; i = i + 1)
      bus(1'b0, i[3:0], 16'h0000);
    // random settings read back; status and value stay read-only
    for (i = 1; i < 16; i = i + 1)
    begin
      r = $random(seed);
      bus(1'b1, i[3:0], r[15:0]);
      bus(1'b0, i[3:0], (i < 14) ? r[15:0] : 16'h0000);
    end
    for (i = 1; i < 14; i = i + 1)
      bus(1'b1, i[3:0], cfg_init[16 * (i - 1) +: 16]);
    step(8'h0A, 4'h0, 16'h0014, 16'hFFFF);
    step(8'h0A, 4'h0, 16'h001E, 16'hFFFF);
    step(8'h0A, 4'h0, 16'h0024, 16'h0000);
    step(8'h0A, 4'h0, 16'h001E, 16'h0000);
    step(8'h0A, 4'h0, 16'h0018, 16'hFFFF);
    step(8'h06, 4'h0, 16'h0028, 16'hFFFF);
    step(8'h06, 4'h0, 16'h001E, 16'hFFFF);
    step(8'h06, 4'h0, 16'h0018, 16'h0000);
    step(8'h02, 4'h0, 16'h0028, 16'h0000);
    step(8'h0E, 4'h0, 16'h001E, 16'hFFFF);
    step(8'h0E, 4'h0, 16'h003C, 16'h0000);
    step(8'h0E, 4'h0, 16'h0002, 16'h0000);
    step(8'h12, 4'h0, 16'h001E, 16'h0000);
    step(8'h12, 4'h0, 16'h003C, 16'hFFFF);
    step(8'h12, 4'h0, 16'h0002, 16'hFFFF);
    step(8'h06, 4'h0, 16'h0018, 16'h0000);
    step(8'h46, 4'h8, 16'h0018, 16'hFFFF);
    step(8'h26, 4'h4, 16'h0018, 16'h0000);
    step(8'h06, 4'h2, 16'h0028, 16'h0000);
    step(8'h86, 4'h8, 16'h0018, 16'hFFFF);
    step(8'h66, 4'h4, 16'h0028, 16'h0000);
    step(8'h06, 4'h0, 16'h0028, 16'hFFFF);
    step(8'h03, 4'h0, 16'h0032, 16'h0190);
    step(8'h03, 4'h0, 16'h0258, 16'h07D0);
    step(8'h03, 4'h0, 16'h012C, 16'h04B0);
    step(8'h03, 4'h1, 16'h012C, 16'h0000);
    step(8'h03, 4'h9, 16'h012C, 16'h0000);
    step(8'h03, 4'h8, 16'h012C, 16'h004D);
    step(8'h03, 4'h4, 16'h012C, 16'h004D);
    step(8'h03, 4'h2, 16'h012C, 16'h004D);
    // falling output range: 200 maps to 2000 - 400
    bus(1'b1, `EOC_OFF_OUT_LO, 16'h07D0);
    bus(1'b1, `EOC_OFF_OUT_HI, 16'h0190);
    step(8'h03, 4'h0, 16'h00C8, 16'h0640);
    for (i = 9; i < 14; i = i + 1)
      bus(1'b1, i[3:0], 16'h0000);
    step(8'h03, 4'h0, 16'h012C, 16'h0000);
    // delays of two ticks, minimum times of six ticks
    for (i = 5; i < 9; i = i + 1)
      bus(1'b1, i[3:0], (i < 7) ? 16'h0002 : 16'h0006);
    step(8'h06, 4'h0, 16'h000A, 16'h0000);
    repeat (100) @(posedge clk);
    meas(16'h0028, 4'h0);
    wait_relay(1'b1);
    chk({15'h0000, n > 0 && n < 40}, 16'h0001);
    meas(16'h000A, 4'h0);
    wait_relay(1'b0);
    chk({15'h0000, n + 9 >= 51 && n < 100}, 16'h0001);
    meas(16'h0028, 4'h0);
    wait_relay(1'b1);
    chk({15'h0000, n + 9 >= 51 && n < 100}, 16'h0001);
    // minimum high time runs out first, then only the turn-off delay holds
    repeat (70) @(posedge clk);
    meas(16'h000A, 4'h0);
    wait_relay(1'b0);
    chk({15'h0000, n > 0 && n < 40}, 16'h0001);
    repeat (4) @(posedge clk);
    summarize;
  end
endmodule // test_eoc_channel
